//--- lintrx_pkg.sv
package lintrx_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_HZ = 25000000;
   localparam int CYC_PER_US = CLK_HZ / 1000000;
   localparam int TIMER_W = 21;
   localparam int DOM_TIMEOUT_MS = 34;
   localparam int DOM_TIMEOUT_MIN_MS = 20;
   localparam int DOM_TIMEOUT_MAX_MS = 80;
   localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * 1000 * CYC_PER_US;
   localparam int WAKE_FILTER_US = 100;
   localparam int WAKE_FILTER_CYC = WAKE_FILTER_US * CYC_PER_US;
   localparam int CLEAR_TIME_US = 17;
   localparam int CLEAR_TIME_CYC = CLEAR_TIME_US * CYC_PER_US;
   localparam int MODE_CHANGE_US = 8;
   localparam int MODE_CHANGE_CYC = MODE_CHANGE_US * CYC_PER_US;

   // ==========================================================
   // Modes
   typedef enum logic [1:0] {
      LINTRX_SLEEP,
      LINTRX_STANDBY,
      LINTRX_NORMAL
   } lintrx_mode_t;

   // ==========================================================
   // Pin groups
   typedef struct packed {
      logic txdIn;
      logic enIn;
      logic wakeIn;
      logic busIn;
      logic overTemp;
      logic supplyOk;
   } lintrx_pins_in_t;

   typedef struct packed {
      logic busDriveDominant;
      logic terminationOn;
      logic rxdOut;
      logic rxdOeN;
      logic txdPullStrong;
      logic inhOut;
      logic inhOeN;
   } lintrx_pins_out_t;
endpackage

//--- lintrx_filter.sv
module lintrx_filter #(
   parameter int CYC = 1
) (
   input  wire logic clk,
   input  wire logic rstSyncN,
   input  wire logic sense,
   output logic      done
);
   // ==========================================================
   // Counts cycles while sense holds, done once the count is met
   logic [lintrx_pkg::TIMER_W-1:0] cnt_r;

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         cnt_r <= '0;
      end else if (!sense) begin
         cnt_r <= '0;
      end else if (cnt_r < lintrx_pkg::TIMER_W'(CYC)) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign done = sense && (cnt_r >= lintrx_pkg::TIMER_W'(CYC));
endmodule

//--- lintrx_core.sv
// Summary of operation
// - In normal mode low transmit input drives bus dominant, high leaves it recessive.
// - In normal mode receive output follows bus: low dominant, high recessive.
// - In standby the receive output is held low as a wake request.
// - Enable high selects normal mode, enable low in normal mode selects sleep.
// - Normal mode is entered from sleep or standby once enable stays high for the mode change time.
// - Enable defaults low when floating, keeping the device in low power.
// - Either edge on the local wake input is a local wake event.
// - A local wake pulls the transmit pin strongly to ground.
// - That strong pull is released on the next enable rising edge.
// - Regulator inhibit output is active in every mode but sleep.
// - In sleep the inhibit output is off and high impedance.
// - In normal mode a falling transmit edge starts the dominant timer.
// - Transmit low past the timeout disables the transmitter.
// - A rising transmit edge clears the timeout protection and timer.
// - During timeout fault stay normal, receive follows bus, termination on.
// - On sleep entry the bus state is sampled for stuck dominant.
// - Stuck dominant at sleep entry locks out bus wake until recessive clears it.
// - Over-temperature forces the transmitter recessive.
// - Transmitter re-enabled when over-temperature clears, if still in normal mode.
// - Power-on reset holds the device inactive while supply is under threshold.
// - Enable high at power up starts normal mode, and the dominant timer if transmit is low.
// - Thermal fault disables transmitter regardless of transmit input.
// - Dominant timeout lies between 20 and 80 ms of continuous low.
// - Bus wake needs dominant for the wake filter time, 25 to 150 us.
// - Stuck-dominant lockout clears after 8 to 50 us recessive.
// - Enable mode change takes effect after 2 to 15 us.
module lintrx_core (
   input  wire logic                         clk,
   input  wire logic                         rstn,
   input  wire lintrx_pkg::lintrx_pins_in_t  pinsIn,
   output lintrx_pkg::lintrx_pins_out_t      pinsOut,
   output lintrx_pkg::lintrx_mode_t          modeOut
);
   // ==========================================================
   // Reset release
   logic rstMeta_r;
   logic rstSyncN;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta_r <= 1'b0;
         rstSyncN  <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSyncN  <= rstMeta_r;
      end
   end

   // ==========================================================
   // Pin input synchronisers
   localparam int NIN = $bits(lintrx_pkg::lintrx_pins_in_t);
   logic [NIN-1:0] syncMeta_r;
   logic [NIN-1:0] syncOut_r;
   lintrx_pkg::lintrx_pins_in_t pin;

   // Pins read as their idle levels until the synchronisers fill; enable idles low
   localparam lintrx_pkg::lintrx_pins_in_t SYNC_IDLE = '{
      txdIn: 1'b1, enIn: 1'b0, wakeIn: 1'b0, busIn: 1'b1, overTemp: 1'b0, supplyOk: 1'b0
   };

   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : gSync
         always_ff @(posedge clk or negedge rstSyncN) begin
            if (!rstSyncN) begin
               syncMeta_r[gi] <= SYNC_IDLE[gi];
               syncOut_r[gi]  <= SYNC_IDLE[gi];
            end else begin
               syncMeta_r[gi] <= pinsIn[gi];
               syncOut_r[gi]  <= syncMeta_r[gi];
            end
         end
      end
   endgenerate

   assign pin = lintrx_pkg::lintrx_pins_in_t'(syncOut_r);

   // Undervoltage acts as a held reset of the mode, wake and timeout state, not of the input filters
   logic active;
   assign active = pin.supplyOk;

   // ==========================================================
   // Edge history
   logic txdPrev_r;
   logic enPrev_r;
   logic wakePrev_r;
   logic busPrev_r;
   logic primed_r;

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         txdPrev_r  <= 1'b1;
         enPrev_r   <= 1'b0;
         wakePrev_r <= 1'b0;
         busPrev_r  <= 1'b1;
         primed_r   <= 1'b0;
      end else begin
         txdPrev_r  <= pin.txdIn;
         enPrev_r   <= pin.enIn;
         wakePrev_r <= pin.wakeIn;
         busPrev_r  <= pin.busIn;
         primed_r   <= active;
      end
   end

   logic txdFall;
   logic txdRise;
   logic enRise;
   logic wakeEdge;
   logic busRise;
   assign txdFall  = txdPrev_r && !pin.txdIn;
   assign txdRise  = !txdPrev_r && pin.txdIn;
   assign enRise   = !enPrev_r && pin.enIn;
   assign wakeEdge = primed_r && (wakePrev_r != pin.wakeIn);
   assign busRise  = !busPrev_r && pin.busIn;

   // ==========================================================
   // Filters
   logic enHighDone;
   logic enLowDone;
   logic busDomDone;
   logic busRecDone;

   lintrx_filter #(.CYC(lintrx_pkg::MODE_CHANGE_CYC)) uEnHigh (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .sense    (pin.enIn),
      .done     (enHighDone)
   );

   lintrx_filter #(.CYC(lintrx_pkg::MODE_CHANGE_CYC)) uEnLow (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .sense    (!pin.enIn),
      .done     (enLowDone)
   );

   lintrx_filter #(.CYC(lintrx_pkg::WAKE_FILTER_CYC)) uBusDom (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .sense    (!pin.busIn),
      .done     (busDomDone)
   );

   lintrx_filter #(.CYC(lintrx_pkg::CLEAR_TIME_CYC)) uBusRec (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .sense    (pin.busIn),
      .done     (busRecDone)
   );

   // ==========================================================
   // Mode state
   lintrx_pkg::lintrx_mode_t mode_r;
   lintrx_pkg::lintrx_mode_t mode_nxt;
   logic busWakeArmed_r;
   logic lockout_r;
   logic busWake;
   logic wakeEvent;

   assign busWake   = busRise && busWakeArmed_r && !lockout_r;
   assign wakeEvent = busWake || wakeEdge;

   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         lintrx_pkg::LINTRX_SLEEP: begin
            if (enHighDone) begin
               mode_nxt = lintrx_pkg::LINTRX_NORMAL;
            end else if (wakeEvent) begin
               mode_nxt = lintrx_pkg::LINTRX_STANDBY;
            end
         end
         lintrx_pkg::LINTRX_STANDBY: begin
            if (enHighDone) begin
               mode_nxt = lintrx_pkg::LINTRX_NORMAL;
            end
         end
         lintrx_pkg::LINTRX_NORMAL: begin
            if (enLowDone) begin
               mode_nxt = lintrx_pkg::LINTRX_SLEEP;
            end
         end
         default: begin
            mode_nxt = lintrx_pkg::LINTRX_SLEEP;
         end
      endcase
   end

   // First active cycle picks the power-up mode from enable
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         mode_r <= lintrx_pkg::LINTRX_SLEEP;
      end else if (!active) begin
         mode_r <= lintrx_pkg::LINTRX_SLEEP;
      end else if (!primed_r) begin
         mode_r <= pin.enIn ? lintrx_pkg::LINTRX_NORMAL
                            : lintrx_pkg::LINTRX_STANDBY;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   logic sleepEntry;
   assign sleepEntry = primed_r && (mode_r != lintrx_pkg::LINTRX_SLEEP)
                       && (mode_nxt == lintrx_pkg::LINTRX_SLEEP);

   // ==========================================================
   // Stuck-dominant lockout
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         lockout_r <= 1'b0;
      end else if (!active) begin
         lockout_r <= 1'b0;
      end else if (sleepEntry) begin
         lockout_r <= !pin.busIn;
      end else if (busRecDone) begin
         lockout_r <= 1'b0;
      end
   end

   // ==========================================================
   // Bus wake qualification
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         busWakeArmed_r <= 1'b0;
      end else if (!active || mode_r != lintrx_pkg::LINTRX_SLEEP || lockout_r) begin
         busWakeArmed_r <= 1'b0;
      end else if (busDomDone) begin
         busWakeArmed_r <= 1'b1;
      end else if (pin.busIn) begin
         busWakeArmed_r <= 1'b0;
      end
   end

   // ==========================================================
   // Local wake strong pull on transmit pin
   logic txdPull_r;

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         txdPull_r <= 1'b0;
      end else if (!active) begin
         txdPull_r <= 1'b0;
      end else if (wakeEdge && mode_r != lintrx_pkg::LINTRX_NORMAL) begin
         txdPull_r <= 1'b1;
      end else if (enRise) begin
         txdPull_r <= 1'b0;
      end
   end

   // ==========================================================
   // Dominant timeout
   logic [lintrx_pkg::TIMER_W-1:0] domCnt_r;
   logic domRun_r;
   logic domFault_r;

   // Entering normal with transmit already low also starts the timer
   logic normalEntryLow;
   assign normalEntryLow = active && !pin.txdIn && (mode_r != lintrx_pkg::LINTRX_NORMAL)
                           && (primed_r ? (mode_nxt == lintrx_pkg::LINTRX_NORMAL)
                                        : pin.enIn);

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         domRun_r <= 1'b0;
         domCnt_r <= '0;
      end else if (!active || mode_r != lintrx_pkg::LINTRX_NORMAL || txdRise) begin
         domRun_r <= normalEntryLow;
         domCnt_r <= '0;
      end else if (txdFall) begin
         domRun_r <= 1'b1;
         domCnt_r <= '0;
      end else if (domRun_r && domCnt_r < lintrx_pkg::TIMER_W'(lintrx_pkg::DOM_TIMEOUT_CYC)) begin
         domCnt_r <= domCnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         domFault_r <= 1'b0;
      end else if (!active || mode_r != lintrx_pkg::LINTRX_NORMAL || txdRise) begin
         domFault_r <= 1'b0;
      end else if (domRun_r
                   && domCnt_r >= lintrx_pkg::TIMER_W'(lintrx_pkg::DOM_TIMEOUT_CYC)) begin
         domFault_r <= 1'b1;
      end
   end

   // ==========================================================
   // Outputs
   logic live;
   logic inNormal;
   logic inStandby;
   logic awake;
   logic txEnable;
   lintrx_pkg::lintrx_pins_out_t out_r;

   // Mode decode, false under low supply and before power-up settles
   function automatic logic liveIn(input logic                     on,
                                   input lintrx_pkg::lintrx_mode_t cur,
                                   input lintrx_pkg::lintrx_mode_t want);
      return on && (cur == want);
   endfunction

   assign live      = active && primed_r;
   assign inNormal  = liveIn(live, mode_r, lintrx_pkg::LINTRX_NORMAL);
   assign inStandby = liveIn(live, mode_r, lintrx_pkg::LINTRX_STANDBY);
   assign awake     = inNormal || inStandby;
   // Fault keeps mode, only the driver goes off
   assign txEnable = inNormal && !domFault_r && !pin.overTemp;

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         out_r.busDriveDominant <= 1'b0;
         out_r.terminationOn    <= 1'b0;
         out_r.rxdOut           <= 1'b0;
         out_r.rxdOeN           <= 1'b1;
         out_r.txdPullStrong    <= 1'b0;
         out_r.inhOut           <= 1'b0;
         out_r.inhOeN           <= 1'b1;
      end else begin
         out_r.busDriveDominant <= txEnable && !pin.txdIn;
         out_r.terminationOn    <= awake;
         out_r.rxdOut           <= 1'b0;
         if (inNormal) begin
            out_r.rxdOeN <= pin.busIn;
         end else if (inStandby) begin
            out_r.rxdOeN <= 1'b0;
         end else begin
            out_r.rxdOeN <= 1'b1;
         end
         out_r.txdPullStrong    <= txdPull_r;
         out_r.inhOut           <= 1'b1;
         out_r.inhOeN           <= !awake;
      end
   end

   assign pinsOut = out_r;
   assign modeOut = mode_r;
endmodule

//--- lintrx_core_properties.sv
module lintrx_core_properties (
   input wire logic                         clk,
   input wire logic                         rstn,
   input wire lintrx_pkg::lintrx_pins_in_t  pinsIn,
   input wire lintrx_pkg::lintrx_pins_out_t pinsOut,
   input wire lintrx_pkg::lintrx_mode_t     modeOut
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam lintrx_pkg::lintrx_mode_t SLP = lintrx_pkg::LINTRX_SLEEP;
   localparam lintrx_pkg::lintrx_mode_t STB = lintrx_pkg::LINTRX_STANDBY;
   localparam lintrx_pkg::lintrx_mode_t NRM = lintrx_pkg::LINTRX_NORMAL;
   logic [19:0] enRun_r;
   logic        enPrev_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========
   // Run length of the enable level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enRun_r  <= 20'h00000;
         enPrev_r <= 1'b0;
      end else begin
         enPrev_r <= pinsIn.enIn;
         enRun_r  <= (pinsIn.enIn != enPrev_r) ? 20'h00001 : enRun_r + 20'h00001;
      end
   end
   // ==========
   // Wake sequences
   sequence sWakeEdge;
      modeOut == SLP && pinsIn.supplyOk && !pinsIn.enIn && $changed(pinsIn.wakeIn);
   endsequence
   sequence sStandbyPull;
      modeOut == STB && pinsOut.txdPullStrong;
   endsequence
   // ==========
   // Properties
   a_tx_follow : assert property (
      (modeOut == NRM && !pinsIn.overTemp && $stable(pinsIn.txdIn))[*4]
      |-> pinsOut.busDriveDominant == !pinsIn.txdIn) else $error("bus drive wrong");
   a_tx_thermal : assert property (
      pinsIn.overTemp[*5] |-> !pinsOut.busDriveDominant) else $error("driver on while hot");
   a_rx_follow : assert property (
      (modeOut == NRM && $stable(pinsIn.busIn))[*4]
      |-> pinsOut.rxdOeN == pinsIn.busIn) else $error("receive output wrong");
   a_rxd_standby : assert property (
      (modeOut == STB)[*2] |-> !pinsOut.rxdOeN) else $error("no wake request");
   a_inh_active : assert property (
      (modeOut != SLP)[*2] |-> !pinsOut.inhOeN && pinsOut.inhOut) else $error("inhibit off");
   a_inh_sleep : assert property (
      (modeOut == SLP)[*2] |-> pinsOut.inhOeN) else $error("inhibit driven in sleep");
   a_supply_low : assert property (
      (!pinsIn.supplyOk)[*5] |-> modeOut == SLP && !pinsOut.busDriveDominant
      && pinsOut.rxdOeN && pinsOut.inhOeN) else $error("active under low supply");
   a_local_wake : assert property (
      sWakeEdge |-> ##[1:8] sStandbyPull) else $error("local wake missed");
   a_pull_release : assert property (
      pinsOut.txdPullStrong && $rose(pinsIn.enIn) |-> ##[1:8] !pinsOut.txdPullStrong)
      else $error("strong pull kept");
   a_wake_normal : assert property (
      $past(modeOut) == STB && modeOut == NRM |-> pinsIn.enIn
      && enRun_r inside {[190:215]}) else $error("normal entry timing");
   a_normal_sleep : assert property (
      $past(modeOut) == NRM && modeOut == SLP && pinsIn.supplyOk && $past(pinsIn.supplyOk, 6)
      |-> !pinsIn.enIn && enRun_r inside {[190:215]}) else $error("sleep entry timing");
endmodule

bind lintrx_core lintrx_core_properties u_props (
   .clk(clk), .rstn(rstn), .pinsIn(pinsIn), .pinsOut(pinsOut), .modeOut(modeOut)
);

//--- lintrx_node.sv
module lintrx_node (
   input  wire logic                         txdCtl,
   input  wire logic                         remoteDom,
   input  wire lintrx_pkg::lintrx_pins_out_t pinsOut,
   output logic                              txdLine,
   output logic                              busLine,
   output logic                              rxdLine
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Wire levels
   assign busLine = !(pinsOut.busDriveDominant || remoteDom);
   assign rxdLine = pinsOut.rxdOeN ? 1'b1 : pinsOut.rxdOut;
   assign txdLine = pinsOut.txdPullStrong ? 1'b0 : txdCtl;
endmodule

//--- lin_transceiver_mode_and_fault_control_test.sv
module lin_transceiver_mode_and_fault_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam lintrx_pkg::lintrx_mode_t SLP = lintrx_pkg::LINTRX_SLEEP;
   localparam lintrx_pkg::lintrx_mode_t STB = lintrx_pkg::LINTRX_STANDBY;
   localparam lintrx_pkg::lintrx_mode_t NRM = lintrx_pkg::LINTRX_NORMAL;
   logic                         clk, rstn, txdCtl, en, wk, remoteDom, hot, sup;
   logic                         txdLine, busLine, rxdLine;
   lintrx_pkg::lintrx_pins_in_t  pinsIn;
   lintrx_pkg::lintrx_pins_out_t pinsOut;
   lintrx_pkg::lintrx_mode_t     modeOut;
   int                           miscompares, cmpCount;
   assign pinsIn = '{txdIn: txdLine, enIn: en, wakeIn: wk, busIn: busLine,
                     overTemp: hot, supplyOk: sup};
   lintrx_core uut (.clk(clk), .rstn(rstn), .pinsIn(pinsIn), .pinsOut(pinsOut),
                    .modeOut(modeOut));
   lintrx_node partner (.txdCtl(txdCtl), .remoteDom(remoteDom), .pinsOut(pinsOut),
                        .txdLine(txdLine), .busLine(busLine), .rxdLine(rxdLine));
   // ==========
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chkBit(input string what, input logic exp, input logic got);
      cmpCount++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chkMode(input lintrx_pkg::lintrx_mode_t exp);
      cmpCount++;
      if (modeOut !== exp) begin
         miscompares++;
         $display("mismatch mode expected %0d seen %0d", exp, modeOut);
      end
   endtask
   task automatic setEn(input logic v);
      en = v;
      cyc(260);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ==========
   // Scenarios
   task automatic tPowerUp();
      chkMode(STB);
      chkBit("rxd", 1'b0, rxdLine);
      chkBit("inhOeN", 1'b0, pinsOut.inhOeN);
      chkBit("inhOut", 1'b1, pinsOut.inhOut);
      $display("test power_up done");
   endtask
   task automatic tNormal();
      setEn(1'b1);
      chkMode(NRM);
      for (int i = 0; i < 2; i++) begin
         txdCtl = i[0];
         cyc(6);
         chkBit("bus", i[0], busLine);
         chkBit("rxd", i[0], rxdLine);
      end
      remoteDom = 1'b1;
      cyc(6);
      chkBit("rxd", 1'b0, rxdLine);
      remoteDom = 1'b0;
      $display("test normal done");
   endtask
   task automatic tThermal();
      txdCtl = 1'b0;
      hot = 1'b1;
      cyc(8);
      chkBit("bus", 1'b1, busLine);
      chkMode(NRM);
      chkBit("term", 1'b1, pinsOut.terminationOn);
      remoteDom = 1'b1;
      cyc(6);
      chkBit("rxd", 1'b0, rxdLine);
      remoteDom = 1'b0;
      hot = 1'b0;
      cyc(8);
      chkBit("bus", 1'b0, busLine);
      txdCtl = 1'b1;
      cyc(6);
      $display("test thermal done");
   endtask
   task automatic tBusWake();
      setEn(1'b0);
      chkMode(SLP);
      chkBit("inhOeN", 1'b1, pinsOut.inhOeN);
      remoteDom = 1'b1;
      cyc(1000);
      remoteDom = 1'b0;
      cyc(20);
      chkMode(SLP);
      remoteDom = 1'b1;
      cyc(2600);
      chkMode(SLP);
      remoteDom = 1'b0;
      cyc(20);
      chkMode(STB);
      chkBit("rxd", 1'b0, rxdLine);
      chkBit("term", 1'b1, pinsOut.terminationOn);
      setEn(1'b1);
      $display("test bus_wake done");
   endtask
   task automatic tLocalWake();
      for (int i = 0; i < 2; i++) begin
         setEn(1'b0);
         wk = ~wk;
         cyc(10);
         chkMode(STB);
         chkBit("txd", 1'b0, txdLine);
         en = 1'b1;
         cyc(10);
         chkBit("txd", 1'b1, txdLine);
         cyc(250);
         chkMode(NRM);
      end
      $display("test local_wake done");
   endtask
   task automatic tStuck();
      remoteDom = 1'b1;
      setEn(1'b0);
      remoteDom = 1'b0;
      cyc(100);
      remoteDom = 1'b1;
      cyc(2600);
      remoteDom = 1'b0;
      cyc(20);
      chkMode(SLP);
      cyc(1250);
      remoteDom = 1'b1;
      cyc(2600);
      remoteDom = 1'b0;
      cyc(20);
      chkMode(STB);
      $display("test stuck_dominant done");
   endtask
   task automatic tSupply();
      setEn(1'b1);
      txdCtl = 1'b0;
      sup = 1'b0;
      cyc(10);
      chkMode(SLP);
      chkBit("bus", 1'b1, busLine);
      chkBit("inhOeN", 1'b1, pinsOut.inhOeN);
      sup = 1'b1;
      cyc(10);
      chkMode(NRM);
      chkBit("bus", 1'b0, busLine);
      txdCtl = 1'b1;
      cyc(6);
      $display("test supply done");
   endtask
   task automatic tEnWake();
      setEn(1'b0);
      chkMode(SLP);
      setEn(1'b1);
      chkMode(NRM);
      chkBit("rxd", 1'b1, rxdLine);
      chkBit("inhOeN", 1'b0, pinsOut.inhOeN);
      $display("test enable_wake done");
   endtask
   // ==========
   // Clock, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      txdCtl = 1'b1;
      en = 1'b0;
      wk = 1'b0;
      remoteDom = 1'b0;
      hot = 1'b0;
      sup = 1'b1;
      miscompares = 0;
      cmpCount = 0;
      cyc(2);
      rstn = 1'b1;
      cyc(10);
      tPowerUp();
      tNormal();
      tThermal();
      tBusWake();
      tLocalWake();
      tStuck();
      tSupply();
      tEnWake();
      finish_test();
   end
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      finish_test();
   end
endmodule
